// ===== shared/cocb_params.svh
// constants for the charger option configuration bank
`ifndef COCB_PARAMS_SVH
`define COCB_PARAMS_SVH
// ----------------------------------------------------------------
// register offsets (command codes)
// ----------------------------------------------------------------
`define COCB_OFS_PROT_BOOST 8'h37
`define COCB_OFS_LIMIT_SRC 8'h38
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define COCB_BIT_EXT_LIMIT 7
`define COCB_BIT_DCHG_EN 15
`define COCB_BIT_DEG_SEL 12
`define COCB_BIT_ADP_FLAG 11
`define COCB_BIT_OC_EN 10
`define COCB_BIT_OC_LEVEL 9
`define COCB_BIT_BOOST_STAT 1
// ----------------------------------------------------------------
// reset values, writable masks, fixed reserved values
// ----------------------------------------------------------------
`define COCB_RST_PROT_BOOST 16'h1240
`define COCB_WMASK_PROT_BOOST 16'h96FC
`define COCB_FIXED_PROT_BOOST 16'h0000
`define COCB_RST_LIMIT_SRC 16'h0384
`define COCB_WMASK_LIMIT_SRC 16'h0080
`define COCB_FIXED_LIMIT_SRC 16'h0304
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define COCB_CLK_MHZ 100
`define COCB_DEG_SHORT_MS 150
`define COCB_DEG_LONG_MS 1300
`define COCB_DEG_SHORT_CYC (`COCB_DEG_SHORT_MS * 1000 * `COCB_CLK_MHZ)
`define COCB_DEG_LONG_CYC (`COCB_DEG_LONG_MS * 1000 * `COCB_CLK_MHZ)
`endif

// ===== shared/cocb_pkg.sv
// types for the charger option configuration bank
package cocb_pkg;
  // which deglitch policy applies to the next adapter insertion
  typedef enum logic [1:0] {
    COCB_INS_FIRST,
    COCB_INS_NORMAL,
    COCB_INS_AFTER_FAULT
  } cocb_ins_state_t;
  typedef logic [15:0] cocb_word_t;
endpackage : cocb_pkg

// ===== core/cocb_deglitch.sv
// rising-edge deglitch filter for the adapter-ok detection
`timescale 1ns/100ps
`default_nettype none
module cocb_deglitch #(
  parameter int CNT_W = 28,
  parameter int SHORT_CYC = 15000000,
  parameter int LONG_CYC = 130000000
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // detection
  input wire logic raw_in,
  input wire logic long_in,
  output logic ok_out,
  output logic rise_out
);
  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (SHORT_CYC < 1 || LONG_CYC < 1 || LONG_CYC >= (64'd1 << CNT_W)) begin : g_chk
    $error("cocb_deglitch: counts do not fit the counter");
  end
  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] count;
  wire [CNT_W-1:0] target = long_in ? CNT_W'(LONG_CYC - 1) : CNT_W'(SHORT_CYC - 1);
  wire reached = !ok_out && raw_in && (count >= target);
  wire [CNT_W-1:0] next_count = (!raw_in || ok_out) ? '0 : count + CNT_W'(1);
  // falling edges pass at once; only a steady high rises the output
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= '0;
      ok_out <= 1'b0;
      rise_out <= 1'b0;
    end else begin
      count <= next_count;
      ok_out <= raw_in && (ok_out || reached);
      rise_out <= reached;
    end
  end
endmodule : cocb_deglitch
`default_nettype wire

// ===== core/cocb_top.sv
// charger option configuration bank: two option registers and adapter-ok deglitch
`timescale 1ns/100ps
`default_nettype none
`include "cocb_params.svh"
module cocb_top #(
  parameter int DEG_SHORT_CYC = `COCB_DEG_SHORT_CYC,
  parameter int DEG_LONG_CYC = `COCB_DEG_LONG_CYC,
  parameter int LIMIT_W = 16
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // register port
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire cocb_pkg::cocb_word_t reg_wdata_in,
  output cocb_pkg::cocb_word_t reg_rdata_out,
  output logic reg_rvalid_out,
  output logic reg_err_out,
  // current limit sources
  input wire logic [LIMIT_W-1:0] charge_reg_limit_in,
  input wire logic [LIMIT_W-1:0] discharge_reg_limit_in,
  input wire logic [LIMIT_W-1:0] current_limit_pin_in,
  output logic [LIMIT_W-1:0] charge_limit_out,
  output logic [LIMIT_W-1:0] discharge_limit_out,
  // adapter detection
  input wire logic adapter_detect_input_in,
  input wire logic adapter_detect_fault_in,
  input wire logic boost_stat_in,
  output logic adapter_ok_pin_out,
  output logic adapter_switch_on_out,
  output logic reverse_block_switch_on_out,
  // control levels
  output logic ext_limit_pin_select_out,
  output logic discharge_reg_enable_out,
  output logic input_overcurrent_enable_out,
  output logic input_overcurrent_level_out,
  output logic [7:2] boost_options_out
);
  import cocb_pkg::*;
  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (LIMIT_W < 1 || LIMIT_W > 16) begin : g_chk
    $error("cocb_top: LIMIT_W must be 1 to 16");
  end
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  // two stages so the release is clean against mclk_in
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end
  // ----------------------------------------------------------------
  // register storage and decode
  // ----------------------------------------------------------------
  cocb_word_t prot_boost;
  cocb_word_t limit_src;
  wire hit_prot = reg_addr_in == `COCB_OFS_PROT_BOOST;
  wire hit_limit = reg_addr_in == `COCB_OFS_LIMIT_SRC;
  wire wr_prot = reg_wr_in && hit_prot;
  wire wr_limit = reg_wr_in && hit_limit;
  // only writable bits take the new value; reserved bits keep fixed values
  wire cocb_word_t next_prot_boost = (prot_boost & ~`COCB_WMASK_PROT_BOOST)
                                   | (reg_wdata_in & `COCB_WMASK_PROT_BOOST);
  wire cocb_word_t next_limit_src = (limit_src & ~`COCB_WMASK_LIMIT_SRC)
                                  | (reg_wdata_in & `COCB_WMASK_LIMIT_SRC);
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      prot_boost <= `COCB_RST_PROT_BOOST;
      limit_src <= `COCB_RST_LIMIT_SRC;
    end else begin
      if (wr_prot) begin
        prot_boost <= next_prot_boost;
      end
      if (wr_limit) begin
        limit_src <= next_limit_src;
      end
    end
  end
  // ----------------------------------------------------------------
  // field views
  // ----------------------------------------------------------------
  wire ext_sel = limit_src[`COCB_BIT_EXT_LIMIT];
  wire deg_sel = prot_boost[`COCB_BIT_DEG_SEL];
  wire adapter_ok;
  // ----------------------------------------------------------------
  // read-back
  // ----------------------------------------------------------------
  // flag and boost status are live; stored copies of those bits are never used
  wire cocb_word_t prot_view = (prot_boost & `COCB_WMASK_PROT_BOOST) | `COCB_FIXED_PROT_BOOST
                             | (16'h0001 << `COCB_BIT_ADP_FLAG) & {16{adapter_ok}}
                             | (16'h0001 << `COCB_BIT_BOOST_STAT) & {16{boost_stat_in}};
  wire cocb_word_t limit_view = (limit_src & `COCB_WMASK_LIMIT_SRC) | `COCB_FIXED_LIMIT_SRC;
  wire cocb_word_t next_rdata = hit_prot ? prot_view : (hit_limit ? limit_view : 16'h0000);
  wire next_err = (reg_rd_in || reg_wr_in) && !hit_prot && !hit_limit;
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_out <= 16'h0000;
      reg_rvalid_out <= 1'b0;
      reg_err_out <= 1'b0;
    end else begin
      reg_rdata_out <= reg_rd_in ? next_rdata : reg_rdata_out;
      reg_rvalid_out <= reg_rd_in;
      reg_err_out <= next_err;
    end
  end
  // ----------------------------------------------------------------
  // current limit selection
  // ----------------------------------------------------------------
  wire [LIMIT_W-1:0] chg_min = (current_limit_pin_in < charge_reg_limit_in)
                             ? current_limit_pin_in : charge_reg_limit_in;
  wire [LIMIT_W-1:0] dchg_min = (current_limit_pin_in < discharge_reg_limit_in)
                              ? current_limit_pin_in : discharge_reg_limit_in;
  wire [LIMIT_W-1:0] next_chg = ext_sel ? chg_min : charge_reg_limit_in;
  wire [LIMIT_W-1:0] next_dchg = ext_sel ? dchg_min : discharge_reg_limit_in;
  // ----------------------------------------------------------------
  // insertion policy
  // ----------------------------------------------------------------
  cocb_ins_state_t ins_state;
  cocb_ins_state_t next_ins_state;
  wire ok_rise;
  // a fault in the same cycle as a completed rise still arms the long delay
  always_comb begin
    next_ins_state = ins_state;
    case (ins_state)
      COCB_INS_FIRST: begin
        if (adapter_detect_fault_in) begin
          next_ins_state = COCB_INS_AFTER_FAULT;
        end else if (ok_rise) begin
          next_ins_state = COCB_INS_NORMAL;
        end
      end
      COCB_INS_NORMAL: begin
        if (adapter_detect_fault_in) begin
          next_ins_state = COCB_INS_AFTER_FAULT;
        end
      end
      COCB_INS_AFTER_FAULT: begin
        if (ok_rise && !adapter_detect_fault_in) begin
          next_ins_state = COCB_INS_NORMAL;
        end
      end
      default: begin
        next_ins_state = COCB_INS_FIRST;
      end
    endcase
  end
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      ins_state <= COCB_INS_FIRST;
    end else begin
      ins_state <= next_ins_state;
    end
  end
  // first insertion short, after a fault long, otherwise the select bit
  wire use_long = (ins_state == COCB_INS_AFTER_FAULT)
               || (ins_state == COCB_INS_NORMAL && deg_sel);
  // ----------------------------------------------------------------
  // deglitch filter
  // ----------------------------------------------------------------
  // a fault forces the detect low so the switches drop at once
  wire detect = adapter_detect_input_in && !adapter_detect_fault_in;
  cocb_deglitch #(
    .CNT_W(28),
    .SHORT_CYC(DEG_SHORT_CYC),
    .LONG_CYC(DEG_LONG_CYC)
  ) u_deglitch (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .raw_in(detect),
    .long_in(use_long),
    .ok_out(adapter_ok),
    .rise_out(ok_rise)
  );
  // ----------------------------------------------------------------
  // output flops
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      charge_limit_out <= '0;
      discharge_limit_out <= '0;
      adapter_ok_pin_out <= 1'b0;
      adapter_switch_on_out <= 1'b0;
      reverse_block_switch_on_out <= 1'b0;
      ext_limit_pin_select_out <= 1'b1;
      discharge_reg_enable_out <= 1'b0;
      input_overcurrent_enable_out <= 1'b0;
      input_overcurrent_level_out <= 1'b1;
      boost_options_out <= 6'h10;
    end else begin
      charge_limit_out <= next_chg;
      discharge_limit_out <= next_dchg;
      adapter_ok_pin_out <= adapter_ok;
      adapter_switch_on_out <= adapter_ok;
      reverse_block_switch_on_out <= adapter_ok;
      ext_limit_pin_select_out <= ext_sel;
      discharge_reg_enable_out <= prot_boost[`COCB_BIT_DCHG_EN];
      input_overcurrent_enable_out <= prot_boost[`COCB_BIT_OC_EN];
      input_overcurrent_level_out <= prot_boost[`COCB_BIT_OC_LEVEL];
      boost_options_out <= prot_boost[7:2];
    end
  end
endmodule : cocb_top
`default_nettype wire

// ===== sim/cocb_chk.sv
// assertion checker for the charger option bank ports
`timescale 1ns/100ps
`default_nettype none
module cocb_chk #(parameter int DEG_SHORT_CYC = 20) (
  // clock, reset, register port
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire cocb_pkg::cocb_word_t reg_wdata_in,
  input wire cocb_pkg::cocb_word_t reg_rdata_out,
  input wire logic reg_rvalid_out,
  // limits, adapter detection and control levels
  input wire logic [15:0] charge_reg_limit_in,
  input wire logic [15:0] current_limit_pin_in,
  input wire logic [15:0] charge_limit_out,
  input wire logic adapter_detect_input_in,
  input wire logic adapter_detect_fault_in,
  input wire logic adapter_ok_pin_out,
  input wire logic ext_limit_pin_select_out,
  input wire logic discharge_reg_enable_out,
  input wire logic input_overcurrent_level_out
);
  import cocb_pkg::*;
  // --------
  // properties
  // --------
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  logic [1:0] up_cnt;
  logic up;
  // outputs follow the registers only once the two-flop reset copy has lifted
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) up_cnt <= 2'h0;
    else if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
  end
  assign up = (up_cnt == 2'h3);
  sequence s_wr37; up && reg_wr_in && reg_addr_in == 8'h37; endsequence
  sequence s_wr38; up && reg_wr_in && reg_addr_in == 8'h38; endsequence
  property p_lim_reg;
    up && !ext_limit_pin_select_out |-> charge_limit_out == $past(charge_reg_limit_in);
  endproperty
  property p_lim_min;
    up && ext_limit_pin_select_out |-> charge_limit_out == (($past(current_limit_pin_in) <
      $past(charge_reg_limit_in)) ? $past(current_limit_pin_in) : $past(charge_reg_limit_in));
  endproperty
  property p_ext_wr; s_wr38 |=> ##1 ext_limit_pin_select_out == $past(reg_wdata_in[7], 2);
  endproperty
  property p_dchg; s_wr37 |=> ##1 discharge_reg_enable_out == $past(reg_wdata_in[15], 2);
  endproperty
  property p_ocl; s_wr37 |=> ##1 input_overcurrent_level_out == $past(reg_wdata_in[9], 2);
  endproperty
  property p_deg; $rose(adapter_ok_pin_out) |-> $past(adapter_detect_input_in, DEG_SHORT_CYC);
  endproperty
  property p_fall; up && $fell(adapter_detect_input_in) |-> ##[1:3] !adapter_ok_pin_out;
  endproperty
  property p_fault; up && adapter_detect_fault_in |-> ##[1:2] !adapter_ok_pin_out;
  endproperty
  property p_flag;
    up && reg_rd_in && reg_addr_in == 8'h37 |=> (reg_rdata_out[11] == adapter_ok_pin_out) ||
      (reg_rdata_out[11] == $past(adapter_ok_pin_out));
  endproperty
  property p_rsv38;
    reg_rvalid_out && $past(reg_addr_in) == 8'h38 |-> (reg_rdata_out & 16'hFF7F) == 16'h0304;
  endproperty
  a_lim_reg: assert property (p_lim_reg) else $error("limit not from register");
  a_lim_min: assert property (p_lim_min) else $error("limit not the lower one");
  a_ext_wr: assert property (p_ext_wr) else $error("select out stale");
  a_dchg: assert property (p_dchg) else $error("discharge enable stale");
  a_deg: assert property (p_deg) else $error("adapter ok too early");
  a_fall: assert property (p_fall) else $error("adapter ok fall late");
  a_fault: assert property (p_fault) else $error("fault kept adapter ok");
  a_flag: assert property (p_flag) else $error("present flag differs");
  a_ocl: assert property (p_ocl) else $error("overcurrent level stale");
  a_rsv38: assert property (p_rsv38) else $error("reserved bits wrong");
endmodule : cocb_chk
bind cocb_top cocb_chk #(.DEG_SHORT_CYC(DEG_SHORT_CYC)) u_chk (.mclk_in(mclk_in),
  .rstn_in(rstn_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
  .charge_reg_limit_in(charge_reg_limit_in), .current_limit_pin_in(current_limit_pin_in),
  .charge_limit_out(charge_limit_out), .adapter_detect_input_in(adapter_detect_input_in),
  .adapter_detect_fault_in(adapter_detect_fault_in), .adapter_ok_pin_out(adapter_ok_pin_out),
  .ext_limit_pin_select_out(ext_limit_pin_select_out),
  .discharge_reg_enable_out(discharge_reg_enable_out),
  .input_overcurrent_level_out(input_overcurrent_level_out));
`default_nettype wire

// ===== sim/cocb_host.sv
// management host model: single-word register reads and writes
`timescale 1ns/100ps
`default_nettype none
module cocb_host (
  // clock
  input wire logic mclk_in,
  // register port towards the bank
  output var logic reg_wr_out,
  output var logic reg_rd_out,
  output var logic [7:0] reg_addr_out,
  output var cocb_pkg::cocb_word_t reg_wdata_out,
  input wire cocb_pkg::cocb_word_t reg_rdata_in,
  input wire logic reg_err_in
);
  import cocb_pkg::*;
  // --------
  // strobes are one-cycle pulses, so each task owns exactly two edges
  // --------
  initial begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 16'h0000;
  end
  task automatic wr_reg(input logic [7:0] a, input cocb_word_t d);
    @(posedge mclk_in);
    reg_wr_out <= 1'b1;
    reg_addr_out <= a;
    reg_wdata_out <= d;
    @(posedge mclk_in);
    reg_wr_out <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output cocb_word_t d, output logic e);
    @(posedge mclk_in);
    reg_rd_out <= 1'b1;
    reg_addr_out <= a;
    @(posedge mclk_in);
    reg_rd_out <= 1'b0;
    #1;
    d = reg_rdata_in;
    e = reg_err_in;
  endtask : rd_reg
endmodule : cocb_host
`default_nettype wire

// ===== sim/charger_option_config_bank_tb_top.sv
// self-checking bench for the charger option configuration bank
`timescale 1ns/100ps
`default_nettype none
module charger_option_config_bank_tb_top;
  import cocb_pkg::*;
  // --------
  // signals and helpers
  // --------
  logic mclk_in, rstn_in, wr, rd, err, rvalid, det, flt, okp, asw, rbs, ext, den, oce, ocl, e;
  logic [7:0] addr;
  logic [7:2] bopt;
  cocb_word_t wdata, rdata, chg_reg, dis_reg, pin_lim, chg_out, dis_out, v;
  int fails, comparisons;
  cocb_host u_host (.mclk_in(mclk_in), .reg_wr_out(wr), .reg_rd_out(rd), .reg_addr_out(addr),
    .reg_wdata_out(wdata), .reg_rdata_in(rdata), .reg_err_in(err));
  // short filter counts keep the run brief
  cocb_top #(.DEG_SHORT_CYC(20), .DEG_LONG_CYC(50)) dut (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .reg_err_out(err),
    .charge_reg_limit_in(chg_reg), .discharge_reg_limit_in(dis_reg),
    .current_limit_pin_in(pin_lim), .charge_limit_out(chg_out), .discharge_limit_out(dis_out),
    .adapter_detect_input_in(det), .adapter_detect_fault_in(flt), .boost_stat_in(1'b0),
    .adapter_ok_pin_out(okp), .adapter_switch_on_out(asw), .reverse_block_switch_on_out(rbs),
    .ext_limit_pin_select_out(ext), .discharge_reg_enable_out(den),
    .input_overcurrent_enable_out(oce), .input_overcurrent_level_out(ocl),
    .boost_options_out(bopt));
  task automatic wrap_up;
    if (fails == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input cocb_word_t x, input cocb_word_t g);
    comparisons++;
    if (g !== x) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", nm, x, g);
    end
  endtask : chk
  task automatic rd_chk(input string nm, input logic [7:0] a, input cocb_word_t x);
    u_host.rd_reg(a, v, e);
    chk(nm, x, v);
    // the valid pulse stands in the cycle after the strobe, which is when the data are taken
    chk("rvalid", 16'h0001, {15'h0, rvalid});
  endtask : rd_chk
  task automatic settle;
    repeat (2) @(posedge mclk_in);
    #1;
  endtask : settle
  // insertion: cycles from detect rise to adapter ok, bounded
  task automatic ins(input int n);
    int c;
    c = 0;
    @(posedge mclk_in);
    det <= 1'b1;
    flt <= 1'b0;
    while (okp !== 1'b1 && c < 200) begin
      @(posedge mclk_in);
      #1;
      c++;
    end
    chk("deglitch", 16'(n), (c >= n && c <= n + 4) ? 16'(n) : 16'(c));
    chk("switches", 16'h0007, {13'h0, okp, asw, rbs});
    if (c >= 200) wrap_up();
  endtask : ins
  task automatic rm;
    @(posedge mclk_in);
    det <= 1'b0;
    repeat (3) @(posedge mclk_in);
    #1;
    chk("fall", 16'h0000, {13'h0, okp, asw, rbs});
  endtask : rm
  // --------
  // scenarios
  // --------
  task automatic t_reset_vals;
    rd_chk("opt3", 8'h37, 16'h1240);
    rd_chk("opt2", 8'h38, 16'h0384);
    chk("ctl", 16'h0109, {6'h0, bopt, ext, den, oce, ocl});
  endtask : t_reset_vals
  task automatic t_limits;
    u_host.wr_reg(8'h38, 16'hFFFF);
    rd_chk("opt2", 8'h38, 16'h0384);
    u_host.wr_reg(8'h38, 16'h0000);
    settle();
    chk("chg", 16'h0100, chg_out);
    chk("dis", 16'h0200, dis_out);
    u_host.wr_reg(8'h38, 16'h0080);
    settle();
    chk("chg", 16'h0040, chg_out);
    chk("dis", 16'h0040, dis_out);
    u_host.rd_reg(8'h50, v, e);
    chk("unmapped", 16'h0000, v);
    chk("err", 16'h0001, {15'h0, e});
  endtask : t_limits
  task automatic t_opt3;
    u_host.wr_reg(8'h37, 16'hFFFF);
    settle();
    rd_chk("opt3", 8'h37, 16'h96FC);
    chk("ctl", 16'h03FF, {6'h0, bopt, ext, den, oce, ocl});
    u_host.wr_reg(8'h37, 16'h0000);
    settle();
    chk("ctl", 16'h0008, {6'h0, bopt, ext, den, oce, ocl});
    u_host.wr_reg(8'h37, 16'h1240);
  endtask : t_opt3
  task automatic t_deglitch;
    ins(20);
    rd_chk("flag", 8'h37, 16'h1A40);
    rm();
    ins(50);
    u_host.wr_reg(8'h37, 16'h0240);
    rm();
    ins(20);
    @(posedge mclk_in);
    flt <= 1'b1;
    repeat (3) @(posedge mclk_in);
    #1;
    chk("fault", 16'h0000, {13'h0, okp, asw, rbs});
    ins(50);
    rm();
    rd_chk("flag", 8'h37, 16'h0240);
  endtask : t_deglitch
  // reset in mid-run: defaults come back and the next insertion counts as the first again
  task automatic t_rereset;
    @(posedge mclk_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    rd_chk("opt3", 8'h37, 16'h1240);
    ins(20);
    rm();
  endtask : t_rereset
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  // main sequence: reset held two cycles, first access after the reset copy lifts
  initial begin
    rstn_in = 1'b0;
    det = 1'b0;
    flt = 1'b0;
    chg_reg = 16'h0100;
    dis_reg = 16'h0200;
    pin_lim = 16'h0040;
    fails = 0;
    comparisons = 0;
    repeat (2) @(posedge mclk_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    t_reset_vals();
    t_limits();
    t_opt3();
    t_deglitch();
    t_rereset();
    wrap_up();
  end
endmodule : charger_option_config_bank_tb_top
`default_nettype wire
